/* File: rtl/servo_io_cmds.sv */
// Overview of operation
// (RULE_01) Done low-active: line 1 low and LED lit when done, else high, dark.
// (RULE_02) Done means nothing pending, no motion, error within limits.
// (RULE_03) Done-low command is code 187, one word, either thread.
// (RULE_04) Driver enabled at reset; enable command restores it after any disable.
// (RULE_05) Host should equalise target and position before re-enabling driver.
// (RULE_06) Driver enable is code 227, one word, thread 1 only.
// (RULE_07) Mode 2 drives internal A, B, index onto lines 4, 5, 6.
// (RULE_08) Mode 3 drives external A, B, index onto lines 4-6; needs port.
// (RULE_09) Mode 4 stops encoder drive on lines 4 to 6.
// (RULE_10) Mode 5 drives internal A and B onto lines 4 and 5.
// (RULE_11) Mode 6 drives external A and B onto lines 4, 5; needs port.
// (RULE_12) Monitored lines are buffered encoder copies, ordinary output drive.
// (RULE_13) Encoder lines refuse bit output; encoder refused over output lines.
// (RULE_14) Routing command is code 192, four words, mode 2-6, zeros.
// (RULE_15) Program suspends during motion unless multitasking is on.
// (RULE_16) Multitask enable is code 225, one word, thread 1 only.
// (RULE_17) Alternate monitor drives internal A, B, index onto lines 1-3.
// (RULE_18) Output conflicts raise a command error and end the program.
// (RULE_19) Multitask disable halts the trajectory at once, no ramp.
// (RULE_20) Routing changes reach lines 4-6 one cycle after execution.
//
// Added by the designer: the placing of the registers and register access over APB.
module servo_io_cmds (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire servo_io_pkg::enc_t enc_int,
	input wire servo_io_pkg::enc_t enc_ext,
	input wire logic kill_motor,
	input wire logic over_voltage,
	input wire logic motion_active,
	input wire logic cmds_pending,
	input wire logic [15:0] pos_error,
	output logic [5:0] io_out,
	output logic [5:0] io_oe,
	output logic green_led,
	output logic driver_enable,
	output logic multitask_on,
	output logic program_suspend,
	output logic halt_trajectory,
	output logic program_terminate,
	output logic cmd_ack,
	output logic cmd_error
);

	// ==========================================================
	// Helpers
	// ==========================================================
	function automatic logic [15:0] abs16(input logic [15:0] v);
		abs16 = v[15] ? 16'(~v + 16'h0001) : v;
	endfunction : abs16

	// Lines 4..6 (bits 3..5) claimed by an encoder routing mode
	function automatic logic [5:0] route_lines(input logic [2:0] m);
		unique case (m)
			servo_io_pkg::MODE_INT_ABZ, servo_io_pkg::MODE_EXT_ABZ:
				route_lines = 6'h38;
			servo_io_pkg::MODE_INT_AB, servo_io_pkg::MODE_EXT_AB:
				route_lines = 6'h18;
			default:
				route_lines = 6'h00;
		endcase
	endfunction : route_lines

	// ==========================================================
	// Pin synchronisers
	// ==========================================================
	logic [7:0] pin_s1_q, pin_s2_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_s1_q <= 8'h00;
			pin_s2_q <= 8'h00;
		end else begin
			pin_s1_q <= {enc_int, enc_ext, kill_motor, over_voltage};
			pin_s2_q <= pin_s1_q;
		end
	end

	servo_io_pkg::enc_t int_s, ext_s;
	logic kill_s, ov_s;
	assign int_s = pin_s2_q[7:5];
	assign ext_s = pin_s2_q[4:2];
	assign kill_s = pin_s2_q[1];
	assign ov_s = pin_s2_q[0];

	// ==========================================================
	// APB decode
	// ==========================================================
	logic setup, wr_acc, rd_hit;
	logic [31:0] prdata_q, prdata_d;
	assign setup = psel & ~penable;
	assign wr_acc = psel & penable & pwrite;
	assign rd_hit = (paddr == servo_io_pkg::CMD_WORD_OFS) ||
		(paddr == servo_io_pkg::STATUS_OFS) ||
		(paddr == servo_io_pkg::THREAD_OFS) ||
		(paddr == servo_io_pkg::IO_CTRL_OFS) ||
		(paddr == servo_io_pkg::ERR_LIMIT_OFS);
	// Zero wait states; read data is captured in the setup cycle
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~rd_hit;

	logic word_wr, io_wr;
	assign word_wr = wr_acc && paddr == servo_io_pkg::CMD_WORD_OFS;
	assign io_wr = wr_acc && paddr == servo_io_pkg::IO_CTRL_OFS;

	logic [2:0] words_held;
	logic cmd_valid;
	servo_io_pkg::cmd_t cmd;

	cmd_assembler u_asm (
		.pclk(pclk),
		.presetn(presetn),
		.word_valid(word_wr),
		.word(pwdata[15:0]),
		.words_held(words_held),
		.cmd_valid(cmd_valid),
		.cmd(cmd)
	);

	// ==========================================================
	// Configuration and run state
	// ==========================================================
	logic thread2_q, thread2_d;
	logic [15:0] limit_q, limit_d;
	logic [5:0] io_mode_q, io_mode_d, io_val_q, io_val_d;
	logic [2:0] mode_q, mode_d;
	logic alt_mon_q, alt_mon_d, done_en_q, done_en_d;
	logic done_low_q, done_low_d, drv_q, drv_d, mt_q, mt_d;
	logic err_q, err_d, conf_q, conf_d;
	logic ack_q, ack_d, errp_q, errp_d, term_q, term_d, halt_q, halt_d;
	logic bad, conflict, need_t1, done;

	// Done test; a zero limit switches the error check off
	assign done = ~cmds_pending & ~motion_active &
		((limit_q == 16'h0000) || (abs16(pos_error) <= limit_q)); // RULE_02

	// Command execution and register writes
	always_comb begin
		thread2_d = thread2_q;
		limit_d = limit_q;
		io_mode_d = io_mode_q;
		io_val_d = io_val_q;
		mode_d = mode_q;
		alt_mon_d = alt_mon_q;
		done_en_d = done_en_q;
		done_low_d = done_low_q;
		drv_d = drv_q;
		mt_d = mt_q;
		err_d = err_q;
		conf_d = conf_q;
		ack_d = 1'b0;
		halt_d = 1'b0;
		bad = 1'b0;
		conflict = 1'b0;
		need_t1 = 1'b0;
		if (wr_acc && paddr == servo_io_pkg::THREAD_OFS) begin
			thread2_d = pwdata[0];
		end
		if (wr_acc && paddr == servo_io_pkg::ERR_LIMIT_OFS) begin
			limit_d = pwdata[15:0];
		end
		// Write-one-to-clear of the sticky flags
		if (wr_acc && paddr == servo_io_pkg::STATUS_OFS) begin
			if (pwdata[servo_io_pkg::ST_ERR_POS]) err_d = 1'b0;
			if (pwdata[servo_io_pkg::ST_CONFLICT_POS]) conf_d = 1'b0;
		end
		if (io_wr) begin
			// Bit output on monitored lines is refused whole
			if ((pwdata[5:0] & (route_lines(mode_q) |
					{3'h0, {3{alt_mon_q}}})) != 6'h00) begin
				conflict = 1'b1; // RULE_13
			end else begin
				io_mode_d = pwdata[servo_io_pkg::IO_MODE_POS +: 6];
				io_val_d = pwdata[servo_io_pkg::IO_VAL_POS +: 6];
			end
		end
		if (cmd_valid) begin
			unique case (cmd.code)
				servo_io_pkg::CODE_DONE_LOW: begin
					done_en_d = 1'b1; // RULE_03
					done_low_d = 1'b1;
				end
				servo_io_pkg::CODE_DONE_HIGH: begin
					done_en_d = 1'b1;
					done_low_d = 1'b0;
				end
				servo_io_pkg::CODE_ENC_MON_LOW: begin
					if ((io_mode_q & 6'h07) != 6'h00) conflict = 1'b1;
					else alt_mon_d = 1'b1; // RULE_17
				end
				servo_io_pkg::CODE_DRV_EN: begin
					need_t1 = 1'b1; // RULE_06
					if (!thread2_q) drv_d = 1'b1; // RULE_04
				end
				servo_io_pkg::CODE_DRV_DIS: begin
					need_t1 = 1'b1;
					if (!thread2_q) drv_d = 1'b0;
				end
				servo_io_pkg::CODE_MT_EN: begin
					need_t1 = 1'b1; // RULE_16
					if (!thread2_q) mt_d = 1'b1;
				end
				servo_io_pkg::CODE_MT_DIS: begin
					need_t1 = 1'b1;
					if (!thread2_q) begin
						mt_d = 1'b0;
						halt_d = 1'b1; // RULE_19
					end
				end
				servo_io_pkg::CODE_ENC_ROUTE: begin
					need_t1 = 1'b1;
					// Range, zero fields and port presence
					if (cmd.mode < 16'h0002 || cmd.mode > 16'h0006 ||
							cmd.index_state != 16'h0000 ||
							cmd.reserved != 16'h0000) begin
						bad = 1'b1; // RULE_14
					end else if (!servo_io_pkg::SSI_PORT_PRESENT &&
							(cmd.mode[2:0] == servo_io_pkg::MODE_EXT_ABZ ||
							cmd.mode[2:0] == servo_io_pkg::MODE_EXT_AB)) begin
						bad = 1'b1; // RULE_08 RULE_11
					end else if ((route_lines(cmd.mode[2:0]) &
							io_mode_q) != 6'h00) begin
						conflict = 1'b1; // RULE_13
					end else if (!thread2_q) begin
						mode_d = cmd.mode[2:0]; // RULE_20
					end
				end
				default: bad = 1'b1;
			endcase
			if (need_t1 && thread2_q) bad = 1'b1;
			ack_d = ~bad & ~conflict;
		end
		// A kill or overvoltage beats an enable in the same cycle
		if (kill_s || ov_s) drv_d = 1'b0; // RULE_04
		// New errors win over a clear in the same cycle
		if (bad || conflict) err_d = 1'b1; // RULE_18
		if (conflict) conf_d = 1'b1;
		errp_d = bad | conflict;
		term_d = conflict; // RULE_18
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			thread2_q <= 1'b0;
			limit_q <= servo_io_pkg::ERR_LIMIT_RST;
			io_mode_q <= servo_io_pkg::IO_OE_RST;
			io_val_q <= 6'h00;
			mode_q <= servo_io_pkg::MODE_OFF;
			alt_mon_q <= 1'b0;
			done_en_q <= 1'b0;
			done_low_q <= 1'b0;
			drv_q <= servo_io_pkg::DRV_EN_RST;
			mt_q <= 1'b0;
			err_q <= 1'b0;
			conf_q <= 1'b0;
			ack_q <= 1'b0;
			errp_q <= 1'b0;
			term_q <= 1'b0;
			halt_q <= 1'b0;
		end else begin
			thread2_q <= thread2_d;
			limit_q <= limit_d;
			io_mode_q <= io_mode_d;
			io_val_q <= io_val_d;
			mode_q <= mode_d;
			alt_mon_q <= alt_mon_d;
			done_en_q <= done_en_d;
			done_low_q <= done_low_d;
			drv_q <= drv_d;
			mt_q <= mt_d;
			err_q <= err_d;
			conf_q <= conf_d;
			ack_q <= ack_d;
			errp_q <= errp_d;
			term_q <= term_d;
			halt_q <= halt_d;
		end
	end

	// ==========================================================
	// Line drive, status outputs and read data
	// ==========================================================
	logic [5:0] out_q, out_d, oe_q, oe_d;
	logic led_q, led_d, susp_q, susp_d;

	// Each line is chosen alone, so untouched lines never glitch
	always_comb begin
		out_d = io_val_q;
		oe_d = io_mode_q; // RULE_12
		if (done_en_q) begin
			oe_d[0] = 1'b1;
			out_d[0] = done ^ done_low_q; // RULE_01
		end
		if (alt_mon_q) begin
			oe_d[2:0] = 3'h7;
			out_d[2:0] = {int_s.z, int_s.b, int_s.a}; // RULE_17
		end
		unique case (mode_q)
			servo_io_pkg::MODE_INT_ABZ: out_d[5:3] =
				{int_s.z, int_s.b, int_s.a}; // RULE_07
			servo_io_pkg::MODE_EXT_ABZ: out_d[5:3] =
				{ext_s.z, ext_s.b, ext_s.a}; // RULE_08
			servo_io_pkg::MODE_INT_AB: out_d[4:3] =
				{int_s.b, int_s.a}; // RULE_10
			servo_io_pkg::MODE_EXT_AB: out_d[4:3] =
				{ext_s.b, ext_s.a}; // RULE_11
			default: ; // RULE_09
		endcase
		oe_d = oe_d | route_lines(mode_q);
		led_d = done_en_q & done; // RULE_01
		// Without multitasking the program waits out each motion
		susp_d = motion_active & ~mt_q; // RULE_15
		prdata_d = prdata_q;
		if (setup && !pwrite) begin
			prdata_d = 32'h0000_0000;
			unique case (paddr)
				servo_io_pkg::STATUS_OFS: begin
					prdata_d[servo_io_pkg::ST_DONE_POS] = done;
					prdata_d[servo_io_pkg::ST_DRV_POS] = drv_q;
					prdata_d[servo_io_pkg::ST_MT_POS] = mt_q;
					prdata_d[servo_io_pkg::ST_ERR_POS] = err_q;
					prdata_d[servo_io_pkg::ST_CONFLICT_POS] = conf_q;
					prdata_d[servo_io_pkg::ST_DONE_EN_POS] = done_en_q;
					prdata_d[servo_io_pkg::ST_DONE_LOW_POS] = done_low_q;
					prdata_d[servo_io_pkg::ST_ALT_MON_POS] = alt_mon_q;
					prdata_d[servo_io_pkg::ST_MODE_POS +: 3] = mode_q;
					prdata_d[servo_io_pkg::ST_WORDS_POS +: 3] = words_held;
				end
				servo_io_pkg::THREAD_OFS: prdata_d[0] = thread2_q;
				servo_io_pkg::IO_CTRL_OFS: begin
					prdata_d[servo_io_pkg::IO_MODE_POS +: 6] = io_mode_q;
					prdata_d[servo_io_pkg::IO_VAL_POS +: 6] = io_val_q;
				end
				servo_io_pkg::ERR_LIMIT_OFS: prdata_d[15:0] = limit_q;
				default: ;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_q <= 6'h00;
			oe_q <= servo_io_pkg::IO_OE_RST;
			led_q <= 1'b0;
			susp_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end else begin
			out_q <= out_d;
			oe_q <= oe_d;
			led_q <= led_d;
			susp_q <= susp_d;
			prdata_q <= prdata_d;
		end
	end

	assign prdata = prdata_q;
	assign io_out = out_q;
	assign io_oe = oe_q;
	assign green_led = led_q;
	assign driver_enable = drv_q;
	assign multitask_on = mt_q;
	assign program_suspend = susp_q;
	assign halt_trajectory = halt_q;
	assign program_terminate = term_q;
	assign cmd_ack = ack_q;
	assign cmd_error = errp_q;

endmodule : servo_io_cmds

/* File: rtl/servo_io_pkg.sv */
package servo_io_pkg;

	// ==========================================================
	// Register map (byte addresses on the APB)
	// ==========================================================
	localparam logic [7:0] CMD_WORD_OFS = 8'h00;
	localparam logic [7:0] STATUS_OFS = 8'h04;
	localparam logic [7:0] THREAD_OFS = 8'h08;
	localparam logic [7:0] IO_CTRL_OFS = 8'h0C;
	localparam logic [7:0] ERR_LIMIT_OFS = 8'h10;

	// ==========================================================
	// Field positions
	// ==========================================================
	localparam int ST_DONE_POS = 0;
	localparam int ST_DRV_POS = 1;
	localparam int ST_MT_POS = 2;
	localparam int ST_ERR_POS = 3;
	localparam int ST_CONFLICT_POS = 4;
	localparam int ST_DONE_EN_POS = 5;
	localparam int ST_DONE_LOW_POS = 6;
	localparam int ST_ALT_MON_POS = 7;
	localparam int ST_MODE_POS = 8;
	localparam int ST_WORDS_POS = 12;
	localparam int IO_MODE_POS = 0;
	localparam int IO_VAL_POS = 8;

	// ==========================================================
	// Reset values
	// ==========================================================
	localparam logic DRV_EN_RST = 1'b1;
	localparam logic [5:0] IO_OE_RST = 6'h00;
	localparam logic [15:0] ERR_LIMIT_RST = 16'h0000;

	// ==========================================================
	// Command codes and routing modes
	// ==========================================================
	localparam logic [15:0] CODE_ENC_MON_LOW = 16'h00AA;
	localparam logic [15:0] CODE_DONE_LOW = 16'h00BB;
	localparam logic [15:0] CODE_DONE_HIGH = 16'h00FB;
	localparam logic [15:0] CODE_ENC_ROUTE = 16'h00C0;
	localparam logic [15:0] CODE_MT_EN = 16'h00E1;
	localparam logic [15:0] CODE_MT_DIS = 16'h00E2;
	localparam logic [15:0] CODE_DRV_EN = 16'h00E3;
	localparam logic [15:0] CODE_DRV_DIS = 16'h00E4;
	localparam logic [2:0] ROUTE_LEN = 3'h4;
	localparam logic [2:0] SHORT_LEN = 3'h1;

	localparam logic [2:0] MODE_INT_ABZ = 3'h2;
	localparam logic [2:0] MODE_EXT_ABZ = 3'h3;
	localparam logic [2:0] MODE_OFF = 3'h4;
	localparam logic [2:0] MODE_INT_AB = 3'h5;
	localparam logic [2:0] MODE_EXT_AB = 3'h6;

	// Builds with no differential encoder port set this to zero
	localparam logic SSI_PORT_PRESENT = 1'b1;

	typedef struct packed {
		logic [15:0] code;
		logic [15:0] mode;
		logic [15:0] index_state;
		logic [15:0] reserved;
	} cmd_t;

	typedef struct packed {
		logic a;
		logic b;
		logic z;
	} enc_t;

endpackage : servo_io_pkg

/* File: rtl/cmd_assembler.sv */
// Gathers command words into one command; the first word sets the length
module cmd_assembler (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic word_valid,
	input wire logic [15:0] word,
	output logic [2:0] words_held,
	output logic cmd_valid,
	output servo_io_pkg::cmd_t cmd
);

	logic [2:0] cnt_q, cnt_d, need_q, need_d;
	logic [15:0] buf_q [0:3];
	logic [15:0] buf_d [0:3];
	logic valid_q, valid_d;

	// ==========================================================
	// Word count and storage
	// ==========================================================
	always_comb begin
		cnt_d = cnt_q;
		need_d = need_q;
		valid_d = 1'b0;
		for (int i = 0; i < 4; i++) begin
			buf_d[i] = buf_q[i];
		end
		if (word_valid) begin
			buf_d[cnt_q[1:0]] = word;
			if (cnt_q == 3'h0) begin
				// Only the routing command carries parameters
				need_d = (word == servo_io_pkg::CODE_ENC_ROUTE) ?
					servo_io_pkg::ROUTE_LEN : servo_io_pkg::SHORT_LEN;
			end
			if (cnt_q + 3'h1 >= need_d) begin
				cnt_d = 3'h0;
				valid_d = 1'b1;
			end else begin
				cnt_d = cnt_q + 3'h1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 3'h0;
			need_q <= 3'h1;
			valid_q <= 1'b0;
			for (int i = 0; i < 4; i++) begin
				buf_q[i] <= 16'h0000;
			end
		end else begin
			cnt_q <= cnt_d;
			need_q <= need_d;
			valid_q <= valid_d;
			for (int i = 0; i < 4; i++) begin
				buf_q[i] <= buf_d[i];
			end
		end
	end

	assign words_held = cnt_q;
	assign cmd_valid = valid_q;
	assign cmd = '{code: buf_q[0], mode: buf_q[1],
		index_state: buf_q[2], reserved: buf_q[3]};

endmodule : cmd_assembler

/* File: tb/servo_io_cmds_asserts.sv */
module servo_io_cmds_checker (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [15:0] pos_error,
	input wire logic kill_motor,
	input wire logic over_voltage,
	input wire logic motion_active,
	input wire logic cmds_pending,
	input wire logic [5:0] io_oe,
	input wire logic green_led,
	input wire logic driver_enable,
	input wire logic multitask_on,
	input wire logic program_suspend,
	input wire logic halt_trajectory,
	input wire logic program_terminate,
	input wire logic cmd_ack,
	input wire logic cmd_error
);
	timeunit 1ns;
	timeprecision 1ps;

	// ==========================================================
	// Helpers
	// ==========================================================
	// Completed writes, split by target word
	logic wr_acc;
	logic cmd_wr;
	logic io_wr;
	assign wr_acc = psel && penable && pwrite;
	assign cmd_wr = wr_acc && paddr == servo_io_pkg::CMD_WORD_OFS;
	assign io_wr = wr_acc && paddr == servo_io_pkg::IO_CTRL_OFS;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// ==========================================================
	// Properties
	// ==========================================================
	// Responses only two edges after a command word or one edge after an IO control write
	AST_RSP_CAUSE: assert property ((cmd_ack || cmd_error) |->
		$past(cmd_wr, 2) || $past(io_wr))
		else $error("Response without a command");
	AST_RSP_ONE: assert property (!(cmd_ack && cmd_error))
		else $error("Ack and error together");
	AST_TERM: assert property (program_terminate |-> cmd_error)
		else $error("Terminate without error");
	// Three cycles cover the done pipeline
	AST_BUSY: assert property ((motion_active || cmds_pending)[*3]
		|=> !green_led) else $error("Done shown while busy");
	AST_IDLE: assert property ((!motion_active && !cmds_pending &&
		pos_error == 16'h0000 && !psel && io_oe[0])[*3] |=> green_led)
		else $error("Done not shown while idle");
	// Pins pass two flops before the driver register
	AST_DRV: assert property ((kill_motor || over_voltage)[*3]
		|=> !driver_enable) else $error("Driver left on");
	AST_SUSP_ON: assert property (motion_active && !multitask_on
		|=> program_suspend) else $error("Program not suspended");
	AST_SUSP_OFF: assert property (!motion_active || multitask_on
		|=> !program_suspend) else $error("Program wrongly suspended");
	AST_HALT: assert property (halt_trajectory |->
		cmd_ack && !multitask_on) else $error("Halt without disable");
	AST_MT: assert property ($rose(multitask_on) |-> cmd_ack)
		else $error("Multitask on without command");
	AST_ROUTE: assert property ($changed(io_oe[5:3]) |->
		$past(cmd_ack) || $past(io_wr) || $past(io_wr, 2))
		else $error("Encoder lines moved without cause");
endmodule : servo_io_cmds_checker

bind servo_io_cmds servo_io_cmds_checker servo_io_cmds_checker_i (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pos_error(pos_error),
	.kill_motor(kill_motor), .over_voltage(over_voltage),
	.motion_active(motion_active), .cmds_pending(cmds_pending),
	.io_oe(io_oe), .green_led(green_led), .driver_enable(driver_enable),
	.multitask_on(multitask_on), .program_suspend(program_suspend),
	.halt_trajectory(halt_trajectory),
	.program_terminate(program_terminate), .cmd_ack(cmd_ack),
	.cmd_error(cmd_error)
);

/* File: tb/host_model.sv */
module host_model (
	input wire logic pclk,
	input wire logic pready,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] cmd_ofs = servo_io_pkg::CMD_WORD_OFS;

	// ==========================================================
	// Bus master
	// ==========================================================
	// Bus idle from time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
	end

	// One transfer; starting on an edge avoids double drives
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Code first; routing carries three more words
	task automatic send_cmd(input logic [15:0] code,
		input logic [15:0] mode, input logic [15:0] idx);
		apb(1'b1, cmd_ofs, {16'h0000, code});
		if (code == servo_io_pkg::CODE_ENC_ROUTE) begin
			apb(1'b1, cmd_ofs, {16'h0000, mode});
			apb(1'b1, cmd_ofs, {16'h0000, idx});
			apb(1'b1, cmd_ofs, 32'h0000_0000);
		end
	endtask : send_cmd
endmodule : host_model

/* File: tb/tb_servo_io_cmds.sv */
module tb_servo_io_cmds;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {
		logic [31:0] val;
		logic [31:0] mask;
	} rd_note_t;
	localparam logic [15:0] rt = servo_io_pkg::CODE_ENC_ROUTE;
	localparam logic [7:0] st = servo_io_pkg::STATUS_OFS;
	localparam logic [7:0] ioc = servo_io_pkg::IO_CTRL_OFS;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	servo_io_pkg::enc_t enc_int = 3'h0;
	servo_io_pkg::enc_t enc_ext = 3'h0;
	servo_io_pkg::enc_t src;
	logic kill_motor = 1'b0;
	logic over_voltage = 1'b0;
	logic motion_active = 1'b0;
	logic cmds_pending = 1'b0;
	logic [15:0] pos_error = 16'h0000;
	logic [5:0] io_out, io_oe;
	logic green_led, driver_enable, multitask_on, program_suspend;
	logic halt_trajectory, program_terminate, cmd_ack, cmd_error;
	int failures = 0;
	int cmp_count = 0;
	int seed;
	rd_note_t rd_q[$];
	rd_note_t note;
	logic [2:0] rsp_q[$];
	logic [2:0] oe_x;
	// Motion, pending, position error, expected done
	logic [18:0] dn_tab [5] = '{19'h40000, 19'h20000, 19'h00016,
		19'h1FFED, 19'h00015};
	logic [47:0] bad_tab [4] = '{{rt, 32'h0007_0000},
		{rt, 32'h0001_0000}, {rt, 32'h0002_0001}, 48'h0099_0000_0000};

	always #10 pclk = ~pclk;

	servo_io_cmds servo_io_cmds_i (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .enc_int(enc_int), .enc_ext(enc_ext),
		.kill_motor(kill_motor), .over_voltage(over_voltage),
		.motion_active(motion_active), .cmds_pending(cmds_pending),
		.pos_error(pos_error), .io_out(io_out), .io_oe(io_oe),
		.green_led(green_led), .driver_enable(driver_enable),
		.multitask_on(multitask_on), .program_suspend(program_suspend),
		.halt_trajectory(halt_trajectory),
		.program_terminate(program_terminate), .cmd_ack(cmd_ack),
		.cmd_error(cmd_error));

	host_model host_model_i (.pclk(pclk), .pready(pready), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata));

	// ==========================================================
	// Checking
	// ==========================================================
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic end_sim();
		if (failures == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : end_sim

	// Read data taken at the completing edge
	always @(posedge pclk) begin
		if (psel && penable && !pwrite && pready === 1'b1) begin
			note = rd_q.pop_front();
			check(prdata & note.mask, note.val);
		end
	end

	// Falling edge: outputs settled, one-cycle pulses still up
	always @(negedge pclk) begin
		if (cmd_ack === 1'b1 || cmd_error === 1'b1) begin
			check({halt_trajectory, program_terminate,
				cmd_error, cmd_ack}, {rsp_q[0], ~rsp_q[0][0]});
			void'(rsp_q.pop_front());
		end
	end

	// ==========================================================
	// Stimulus
	// ==========================================================
	// Lines move one edge after the answer, three edges after a pin change
	task automatic wait_io();
		repeat (3) @(posedge pclk);
		@(negedge pclk);
	endtask : wait_io

	task automatic cmd(input logic [15:0] c, input logic [15:0] m,
		input logic [15:0] x, input logic [2:0] err);
		rsp_q.push_back(err);
		host_model_i.send_cmd(c, m, x);
		wait_io();
	endtask : cmd

	task automatic rd(input logic [7:0] a, input logic [31:0] v,
		input logic [31:0] m);
		rd_q.push_back('{v, m});
		host_model_i.apb(1'b0, a, 32'h0000_0000);
	endtask : rd

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		host_model_i.apb(1'b1, a, d);
		wait_io();
	endtask : wr

	initial begin
		seed = $urandom(32'hE2174ED6);
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(negedge pclk);
		check({25'h0, io_oe, driver_enable}, 32'h1);
		rd(st, 32'h0000_0403, 32'h0000_77FF);
		rd(8'h14, 32'h0000_0000, 32'hFFFF_FFFF);
		// Done indicator from the second thread, across input cases
		wr(servo_io_pkg::THREAD_OFS, 32'h0000_0001);
		cmd(servo_io_pkg::CODE_DONE_LOW, 16'h0000, 16'h0000, 1'b0);
		wr(servo_io_pkg::ERR_LIMIT_OFS, 32'h0000_000A);
		foreach (dn_tab[i]) begin
			@(posedge pclk);
			{motion_active, cmds_pending, pos_error} <= dn_tab[i][18:1];
			wait_io();
			check({io_oe[0], io_out[0], green_led},
				{1'b1, ~dn_tab[i][0], dn_tab[i][0]});
		end
		cmd(servo_io_pkg::CODE_DONE_HIGH, 16'h0000, 16'h0000, 1'b0);
		check({io_out[0], green_led}, 2'h3);
		// Thread 1 only codes refused from thread 2
		cmd(servo_io_pkg::CODE_MT_EN, 16'h0000, 16'h0000, 1'b1);
		cmd(servo_io_pkg::CODE_DRV_DIS, 16'h0000, 16'h0000, 1'b1);
		cmd(rt, 16'h0002, 16'h0000, 1'b1);
		check({io_oe[5:3], multitask_on, driver_enable}, 5'h01);
		wr(servo_io_pkg::THREAD_OFS, 32'h0000_0000);
		// Suspension while moving, then multitask on and off
		@(posedge pclk);
		motion_active <= 1'b1;
		wait_io();
		check({multitask_on, program_suspend}, 2'h1);
		cmd(servo_io_pkg::CODE_MT_EN, 16'h0000, 16'h0000, 1'b0);
		check({multitask_on, program_suspend}, 2'h2);
		cmd(servo_io_pkg::CODE_MT_DIS, 16'h0000, 16'h0000, 3'h4);
		check({multitask_on, program_suspend}, 2'h1);
		// Disable by command, kill and overvoltage; enable restores
		for (int i = 0; i < 3; i++) begin
			@(posedge pclk);
			motion_active <= 1'b0;
			kill_motor <= (i == 1);
			over_voltage <= (i == 2);
			if (i == 0) cmd(servo_io_pkg::CODE_DRV_DIS, 16'h0000, 16'h0000, 1'b0);
			else wait_io();
			check({31'h0, driver_enable}, 32'h0);
			@(posedge pclk);
			kill_motor <= 1'b0;
			over_voltage <= 1'b0;
			pos_error <= 16'h0000;
			cmd(servo_io_pkg::CODE_DRV_EN, 16'h0000, 16'h0000, 1'b0);
			check({31'h0, driver_enable}, 32'h1);
		end
		// Every routing mode, then fresh encoder values under it
		for (int m = 2; m <= 6; m++) begin
			for (int k = 0; k < 2; k++) begin
				@(posedge pclk);
				enc_int <= 3'($urandom());
				enc_ext <= 3'($urandom());
				if (k == 0) cmd(rt, 16'(m), 16'h0000, 1'b0);
				else wait_io();
				src = (m == 3 || m == 6) ? enc_ext : enc_int;
				oe_x = (m == 4) ? 3'h0 : (m > 4) ? 3'h3 : 3'h7;
				check({io_oe[5:3], io_out[5:3]},
					{oe_x, oe_x & {src.z, src.b, src.a}});
			end
		end
		foreach (bad_tab[i])
			cmd(bad_tab[i][47:32], bad_tab[i][31:16], bad_tab[i][15:0], 1'b1);
		check({29'h0, io_oe[5:3]}, 32'h3);
		// Conflicts between encoder routing and bit outputs
		cmd(rt, 16'h0002, 16'h0000, 1'b0);
		rsp_q.push_back(3'h3);
		wr(ioc, 32'h0000_0808);
		rd(ioc, 32'h0000_0000, 32'h0000_3F3F);
		rd(st, 32'h0000_0010, 32'h0000_0010);
		wr(st, 32'h0000_0010);
		rd(st, 32'h0000_0000, 32'h0000_0010);
		cmd(rt, 16'h0004, 16'h0000, 1'b0);
		wr(ioc, 32'h0000_1010);
		cmd(rt, 16'h0002, 16'h0000, 3'h3);
		check({io_oe[5:3], io_out[5:3]}, 6'h12);
		// Alternate monitor takes lines 1 to 3
		@(posedge pclk);
		enc_int <= 3'($urandom());
		cmd(servo_io_pkg::CODE_ENC_MON_LOW, 16'h0000, 16'h0000, 1'b0);
		check({io_oe[2:0], io_out[2:0]},
			{3'h7, enc_int.z, enc_int.b, enc_int.a});
		end_sim();
	end

	// Traffic needs a few hundred cycles; stop at twenty thousand
	initial begin
		#400000;
		failures++;
		end_sim();
	end
endmodule : tb_servo_io_cmds
